// ===== src/dpsc_dual_port.sv
// two-port synchronous static ram with 18-bit words and byte lanes
// assumes both ports and their bus controllers share clk_in
`timescale 1ns/100ps
module dpsc_dual_port
#(
    parameter int ADDR_W = dpsc_pkg::DPSC_ADDR_W,
    parameter int DATA_W = dpsc_pkg::DPSC_DATA_W
)
(
    input  wire logic              clk_in,                // both ports
    input  wire logic              rst_in,                // async, high
    input  wire logic [1:0]        output_latency_select_in, // 1 = pipelined
    input  wire logic [1:0]        chip_select_active_low_in,  // low selects
    input  wire logic [1:0]        chip_select_active_high_in, // high selects
    input  wire logic [1:0]        upper_byte_select_n_in, // upper lane
    input  wire logic [1:0]        lower_byte_select_n_in, // lower lane
    input  wire logic [1:0]        read_not_write_in,     // 1 read, 0 write
    input  wire logic [1:0]        output_enable_n_in,    // async, low on
    input  wire logic [1:0]        address_strobe_n_in,   // load address
    input  wire logic [1:0]        count_advance_n_in,    // count up
    input  wire logic [1:0]        counter_clear_n_in,    // zero counter
    input  wire logic [ADDR_W-1:0] addr_p0_in,            // port 0 address
    input  wire logic [ADDR_W-1:0] addr_p1_in,            // port 1 address
    input  wire logic [DATA_W-1:0] data_p0_in,            // port 0 pin in
    input  wire logic [DATA_W-1:0] data_p1_in,            // port 1 pin in
    output logic      [DATA_W-1:0] data_p0_out,           // port 0 pin out
    output logic      [DATA_W-1:0] data_p1_out,           // port 1 pin out
    output logic      [1:0]        data_oe_p0_out,        // {upper,lower}
    output logic      [1:0]        data_oe_p1_out         // {upper,lower}
);
    import dpsc_pkg::*;

    localparam int LW = DATA_W / DPSC_LANES;  // lane width

    logic [DATA_W-1:0] mem_q [2**ADDR_W];     // shared array

    logic [ADDR_W-1:0] addr_ext  [DPSC_PORTS]; // external address per port
    logic [ADDR_W-1:0] addr_used [DPSC_PORTS]; // address of this edge
    logic [DATA_W-1:0] din       [DPSC_PORTS]; // write data per port
    logic [DATA_W-1:0] rd_word   [DPSC_PORTS]; // array word read now
    logic [DPSC_PORTS-1:0] sel_now;            // both selects true now
    logic [DPSC_PORTS-1:0] wr_sel;             // write accepted now

    // per-port pipeline state
    logic [DPSC_PORTS-1:0] cs1_q, cs1_d;       // select, stage one
    logic [DPSC_PORTS-1:0] rd1_q, rd1_d;       // read, stage one
    logic [1:0]        lane_q  [DPSC_PORTS];   // lanes driven
    logic [1:0]        lane_d  [DPSC_PORTS];
    logic [DATA_W-1:0] dpipe_q [DPSC_PORTS];   // extra pipelined stage
    logic [DATA_W-1:0] dpipe_d [DPSC_PORTS];
    logic [DATA_W-1:0] dout_q  [DPSC_PORTS];   // word on the pins
    logic [DATA_W-1:0] dout_d  [DPSC_PORTS];

    assign addr_ext[0] = addr_p0_in;
    assign addr_ext[1] = addr_p1_in;
    assign din[0]      = data_p0_in;
    assign din[1]      = data_p1_in;

    // one counter per port; each port steers its own access
    generate
        for (genvar p = 0; p < DPSC_PORTS; p++)
        begin : g_ctr
            dpsc_addr_counter #(.ADDR_W(ADDR_W)) u_ctr
            (
                .clk_in        (clk_in),
                .rst_in        (rst_in),
                .addr_in       (addr_ext[p]),
                .strobe_n_in   (address_strobe_n_in[p]),
                .advance_n_in  (count_advance_n_in[p]),
                .clear_n_in    (counter_clear_n_in[p]),
                .addr_used_out (addr_used[p]),
                .addr_held_out ()
            );
        end
    endgenerate

    // select, write and read decode, plus next pipeline values
    always_comb
    begin
        for (int p = 0; p < DPSC_PORTS; p++)
        begin
            sel_now[p] = !chip_select_active_low_in[p]
                         && chip_select_active_high_in[p];
            wr_sel[p]  = sel_now[p] && !read_not_write_in[p];
            rd_word[p] = mem_q[addr_used[p]];
            cs1_d[p]   = sel_now[p];
            rd1_d[p]   = read_not_write_in[p];
            // flow: select of this edge; pipelined: select of last edge
            if (output_latency_select_in[p])
                lane_d[p] = {!upper_byte_select_n_in[p],
                             !lower_byte_select_n_in[p]}
                            & {2{cs1_q[p] && rd1_q[p]}};
            else
                lane_d[p] = {!upper_byte_select_n_in[p],
                             !lower_byte_select_n_in[p]}
                            & {2{sel_now[p] && read_not_write_in[p]}};
            dpipe_d[p] = rd_word[p];
            // pipelined mode shows the word one edge later
            dout_d[p]  = output_latency_select_in[p] ? dpipe_q[p]
                                                     : rd_word[p];
        end
    end

    // register the port pipelines
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cs1_q <= {DPSC_PORTS{DPSC_BIT_RST}};
            rd1_q <= {DPSC_PORTS{DPSC_BIT_RST}};
            for (int p = 0; p < DPSC_PORTS; p++)
            begin
                lane_q[p]  <= DPSC_LANE_RST;
                dpipe_q[p] <= DATA_W'(DPSC_DATA_RST);
                dout_q[p]  <= DATA_W'(DPSC_DATA_RST);
            end
        end
        else
        begin
            cs1_q <= cs1_d;
            rd1_q <= rd1_d;
            for (int p = 0; p < DPSC_PORTS; p++)
            begin
                lane_q[p]  <= lane_d[p];
                dpipe_q[p] <= dpipe_d[p];
                dout_q[p]  <= dout_d[p];
            end
        end
    end

    // array writes; no reset, like real cells; port 1 wins a same-word clash
    always_ff @(posedge clk_in)
    begin
        for (int p = 0; p < DPSC_PORTS; p++)
        begin
            if (wr_sel[p] && !lower_byte_select_n_in[p])
                mem_q[addr_used[p]][LW-1:0] <= din[p][LW-1:0];
            if (wr_sel[p] && !upper_byte_select_n_in[p])
                mem_q[addr_used[p]][DATA_W-1:LW] <= din[p][DATA_W-1:LW];
        end
    end

    // output enable gates the lanes with no clock in the path
    assign data_p0_out    = dout_q[0];
    assign data_p1_out    = dout_q[1];
    assign data_oe_p0_out = lane_q[0] & {2{!output_enable_n_in[0]}};
    assign data_oe_p1_out = lane_q[1] & {2{!output_enable_n_in[1]}};

    logic [1:0] oe_vis [DPSC_PORTS];  // helper: driven lanes per port
    assign oe_vis[0] = data_oe_p0_out;
    assign oe_vis[1] = data_oe_p1_out;

    generate
        for (genvar p = 0; p < DPSC_PORTS; p++)
        begin : g_chk
            a_oe_float: assert property (@(posedge clk_in)
                disable iff (rst_in)
                output_enable_n_in[p] |-> oe_vis[p] == 2'h0)
                else $error("lanes driven while output enable high");
            a_read_upper: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (!output_latency_select_in[p] && sel_now[p]
                 && read_not_write_in[p] && !upper_byte_select_n_in[p]
                 && lower_byte_select_n_in[p]) |=> lane_q[p] == 2'h2)
                else $error("upper-only read drove wrong lanes");
            a_ft_deselect: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (!output_latency_select_in[p] && !sel_now[p])
                |=> lane_q[p] == 2'h0)
                else $error("flow-through deselect not immediate");
            a_pipe_deselect: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (output_latency_select_in[p] && !sel_now[p]
                 ##1 output_latency_select_in[p]) |=> lane_q[p] == 2'h0)
                else $error("pipelined deselect not after two edges");
            a_bs_single: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (output_latency_select_in[p] && upper_byte_select_n_in[p])
                |=> !lane_q[p][1])
                else $error("byte select took more than one stage");
            a_write_lower: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (wr_sel[p] && !lower_byte_select_n_in[p]
                 && upper_byte_select_n_in[p] && !wr_sel[1-p])
                // case equality: cells never written read back unknown
                |=> mem_q[$past(addr_used[p])][LW-1:0]
                    === $past(din[p][LW-1:0])
                 && mem_q[$past(addr_used[p])][DATA_W-1:LW]
                    === $past(rd_word[p][DATA_W-1:LW]))
                else $error("lower-only write touched wrong lanes");
            a_pipe_delay: assert property (@(posedge clk_in)
                disable iff (rst_in)
                (output_latency_select_in[p] ##1 output_latency_select_in[p])
                |=> dout_q[p] === $past(rd_word[p], 2))
                else $error("pipelined data not one cycle later");
            a_ft_data: assert property (@(posedge clk_in)
                disable iff (rst_in)
                !output_latency_select_in[p]
                |=> dout_q[p] === $past(rd_word[p]))
                else $error("flow-through data not after one edge");
        end
    endgenerate
endmodule // dpsc_dual_port

// ===== src/dpsc_pkg.sv
// shared constants for the dual-port sram port control block
// assumes one system clock drives both ports and the external controllers
package dpsc_pkg;
    localparam int          DPSC_ADDR_W   = 13;      // array address width
    localparam int          DPSC_DATA_W   = 18;      // word width
    localparam int          DPSC_LANE_W   = 9;       // one byte lane
    localparam int          DPSC_LANES    = 2;       // upper and lower lane
    localparam int          DPSC_PORTS    = 2;       // two independent ports
    localparam logic [12:0] DPSC_ADDR_RST = 13'h0000; // counter after reset
    localparam logic [17:0] DPSC_DATA_RST = 18'h00000; // output word at reset
    localparam logic [1:0]  DPSC_LANE_RST = 2'h0;    // no lane driven
    localparam logic        DPSC_BIT_RST  = 1'h0;    // single flag at reset
endpackage

// ===== src/dpsc_addr_counter.sv
// burst address counter for one port: clear, load, advance, hold
// assumes control inputs come from logic on the same clock
`timescale 1ns/100ps
module dpsc_addr_counter
#(
    parameter int ADDR_W = dpsc_pkg::DPSC_ADDR_W
)
(
    input  wire logic              clk_in,          // port clock
    input  wire logic              rst_in,          // async reset, high
    input  wire logic [ADDR_W-1:0] addr_in,         // external address
    input  wire logic              strobe_n_in,     // load when low
    input  wire logic              advance_n_in,    // count when low
    input  wire logic              clear_n_in,      // zero when low
    output logic      [ADDR_W-1:0] addr_used_out,   // address for this edge
    output logic      [ADDR_W-1:0] addr_held_out    // address latched
);
    import dpsc_pkg::*;

    logic [ADDR_W-1:0] addr_q;  // held internal address
    logic [ADDR_W-1:0] addr_d;  // next held address

    // clear beats load, load beats advance, else hold
    always_comb
    begin
        if (!clear_n_in)
            addr_d = ADDR_W'(DPSC_ADDR_RST);
        else if (!strobe_n_in)
            addr_d = addr_in;
        else if (!advance_n_in)
            addr_d = ADDR_W'(addr_q + 1'b1);
        else
            addr_d = addr_q;
    end

    // the used address is the new one, so access follows the edge at once
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            addr_q <= ADDR_W'(DPSC_ADDR_RST);
        else
            addr_q <= addr_d;
    end

    assign addr_used_out = addr_d;
    assign addr_held_out = addr_q;

    a_ctr_load: assert property (@(posedge clk_in) disable iff (rst_in)
        (!strobe_n_in && clear_n_in) |=> addr_q == $past(addr_in))
        else $error("counter did not load the external address");
    a_ctr_advance: assert property (@(posedge clk_in) disable iff (rst_in)
        (strobe_n_in && clear_n_in && !advance_n_in)
        |=> addr_q == ADDR_W'($past(addr_q) + 1'b1))
        else $error("counter did not advance by one");
    a_ctr_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (strobe_n_in && clear_n_in && advance_n_in) |=> $stable(addr_q))
        else $error("counter changed while held");
    a_ctr_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        !clear_n_in |=> addr_q == '0)
        else $error("counter not cleared to zero");
endmodule // dpsc_addr_counter

// ===== bench/dpsc_bus_model.sv
// bus controller model standing at the far side of both ram ports
// assumes the bench calls drive once per edge, one request per port
`timescale 1ns/100ps
module dpsc_bus_model
(
    input  wire logic                         clk_in,      // shared clock
    output logic [8:0]                        ctl_p0_out,  // port 0 controls
    output logic [8:0]                        ctl_p1_out,  // port 1 controls
    output logic [dpsc_pkg::DPSC_ADDR_W-1:0]  addr_p0_out, // port 0 address
    output logic [dpsc_pkg::DPSC_ADDR_W-1:0]  addr_p1_out, // port 1 address
    output logic [dpsc_pkg::DPSC_DATA_W-1:0]  data_p0_out, // port 0 pins
    output logic [dpsc_pkg::DPSC_DATA_W-1:0]  data_p1_out  // port 1 pins
);
    import dpsc_pkg::*;
    // idle: deselected, lanes off, counter holding
    initial
    begin
        ctl_p0_out = 9'h17f;
        ctl_p1_out = 9'h17f;
        addr_p0_out = 13'h0000;
        addr_p1_out = 13'h0000;
        data_p0_out = 18'h00000;
        data_p1_out = 18'h00000;
    end
    // both ports change together just after an edge, held a full cycle
    task automatic drive(input logic [8:0] c0, c1,
                         input logic [12:0] a0, a1,
                         input logic [17:0] d0, d1);
        @(posedge clk_in);
        ctl_p0_out <= c0;
        ctl_p1_out <= c1;
        addr_p0_out <= a0;
        addr_p1_out <= a1;
        // on reads the pins are released: show the inverse, never a copy
        data_p0_out <= c0[4] ? ~data_p0_out : d0;
        data_p1_out <= c1[4] ? ~data_p1_out : d1;
    endtask
endmodule // dpsc_bus_model

// ===== bench/tb_dual_port_sram_port_control.sv
// self-checking bench for the dual-port ram port control
// assumes the bus model drives all controls but lat, set by the bench; ctl = {cs_n,cs,upper_n,
// lower_n,rw,oe_n,strobe_n,advance_n,clear_n}
`timescale 1ns/100ps
module tb_dual_port_sram_port_control;
    import dpsc_pkg::*;
    localparam logic [8:0]  RD  = 9'h093;    // selected read with load
    localparam logic [8:0]  WR  = 9'h083;    // selected write with load
    localparam logic [8:0]  ID  = 9'h17f;    // idle port
    localparam logic [17:0] ALL = 18'h3ffff; // whole word
    logic        clk_in = 1'b0;  // 40 mhz
    logic        rst_in = 1'b1;  // held at start
    logic [1:0]  lat = 2'h0;     // latency per port
    logic [8:0]  c0, c1;         // controls from model
    logic [12:0] a0, a1;         // addresses
    logic [17:0] d0, d1, q0, q1; // pins in, words out
    logic [1:0]  oe0, oe1;       // lane enables
    int          bad_count = 0;  // mismatches
    int          num_checks = 0; // comparisons
    int          cycles = 0;     // timeout count
    dpsc_bus_model bus
    (
        .clk_in      (clk_in),
        .ctl_p0_out  (c0),
        .ctl_p1_out  (c1),
        .addr_p0_out (a0),
        .addr_p1_out (a1),
        .data_p0_out (d0),
        .data_p1_out (d1)
    );
    dpsc_dual_port dut
    (
        .clk_in                     (clk_in),
        .rst_in                     (rst_in),
        .output_latency_select_in   (lat),
        .chip_select_active_low_in  ({c1[8], c0[8]}),
        .chip_select_active_high_in ({c1[7], c0[7]}),
        .upper_byte_select_n_in     ({c1[6], c0[6]}),
        .lower_byte_select_n_in     ({c1[5], c0[5]}),
        .read_not_write_in          ({c1[4], c0[4]}),
        .output_enable_n_in         ({c1[3], c0[3]}),
        .address_strobe_n_in        ({c1[2], c0[2]}),
        .count_advance_n_in         ({c1[1], c0[1]}),
        .counter_clear_n_in         ({c1[0], c0[0]}),
        .addr_p0_in                 (a0),
        .addr_p1_in                 (a1),
        .data_p0_in                 (d0),
        .data_p1_in                 (d1),
        .data_p0_out                (q0),
        .data_p1_out                (q1),
        .data_oe_p0_out             (oe0),
        .data_oe_p1_out             (oe1)
    );
    always #12.5 clk_in = ~clk_in;
    // hang guard: the sequence needs well under 200 cycles
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    // one comparison, case equality so unknowns never match
    task automatic chk(input string what, input logic [17:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request on port p, the other port idle
    task automatic op(input int p, input logic [8:0] c,
                      input logic [12:0] a, input logic [17:0] d);
        if (p == 0)
            bus.drive(c, ID, a, 13'h0000, d, 18'h00000);
        else
            bus.drive(ID, c, 13'h0000, a, 18'h00000, d);
    endtask
    // n edges on, compare lanes and the masked word of port p
    task automatic look(input int p, input int n, input logic [1:0] eoe,
                        input logic [17:0] ed, mk);
        repeat (n) @(posedge clk_in);
        #1;
        chk("lane enables", {16'h0000, p ? oe1 : oe0}, {16'h0000, eoe});
        chk("read word", (p ? q1 : q0) & mk, ed & mk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence: flow-through lanes, counter, then pipelined port 1
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        op(0, WR, 13'h0005, 18'h2a5a5);
        op(0, WR ^ 9'h040, 13'h0006, 18'h3ffff);
        op(0, WR ^ 9'h060, 13'h0006, 18'h00000);
        op(0, WR ^ 9'h100, 13'h0005, 18'h00000);
        op(1, RD, 13'h0005, 18'h00000);
        look(1, 1, 2'h3, 18'h2a5a5, ALL);
        op(1, RD ^ 9'h040, 13'h0006, 18'h00000);
        look(1, 1, 2'h1, 18'h001ff, 18'h001ff);
        op(1, RD ^ 9'h020, 13'h0005, 18'h00000);
        look(1, 1, 2'h2, 18'h2a5a5, 18'h3fe00);
        bus.drive(WR, RD, 13'h0007, 13'h0005, 18'h15555, 18'h00000);
        look(1, 1, 2'h3, 18'h2a5a5, ALL);
        op(1, RD, 13'h0007, 18'h00000);
        look(1, 1, 2'h3, 18'h15555, ALL);
        op(1, RD ^ 9'h008, 13'h0005, 18'h00000);
        look(1, 0, 2'h0, 18'h00000, 18'h00000);
        op(1, RD ^ 9'h100, 13'h0005, 18'h00000);
        look(1, 1, 2'h0, 18'h00000, 18'h00000);
        op(0, WR, 13'h1fff, 18'h11111);
        op(0, WR ^ 9'h006, 13'h0aaa, 18'h22222);
        op(0, WR ^ 9'h004, 13'h0123, 18'h33333);
        op(1, RD, 13'h0000, 18'h00000);
        look(1, 1, 2'h3, 18'h33333, ALL);
        op(0, WR ^ 9'h001, 13'h0005, 18'h04444);
        op(1, RD, 13'h0005, 18'h00000);
        look(1, 1, 2'h3, 18'h2a5a5, ALL);
        op(1, RD, 13'h0000, 18'h00000);
        look(1, 1, 2'h3, 18'h04444, ALL);
        op(0, WR ^ 9'h102, 13'h1fff, 18'h00000);
        op(0, RD ^ 9'h004, 13'h0000, 18'h00000);
        look(0, 1, 2'h3, 18'h11111, ALL);
        // port 1 pipelined, port 0 stays flow-through
        @(posedge clk_in);
        lat <= 2'h2;
        op(1, RD ^ 9'h100, 13'h0000, 18'h00000);
        look(1, 2, 2'h0, 18'h00000, 18'h00000);
        op(1, RD, 13'h1fff, 18'h00000);
        look(1, 1, 2'h0, 18'h00000, 18'h00000);
        look(1, 1, 2'h3, 18'h11111, ALL);
        op(1, RD ^ 9'h040, 13'h1fff, 18'h00000);
        look(1, 1, 2'h1, 18'h11111, 18'h001ff);
        op(1, RD ^ 9'h100, 13'h1fff, 18'h00000);
        look(1, 1, 2'h3, 18'h11111, ALL);
        look(1, 1, 2'h0, 18'h00000, 18'h00000);
        end_of_test();
    end
endmodule // tb_dual_port_sram_port_control
